/* core/dcs_defs.svh */
// Register map, field positions, control reset value and chip tables
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

`define DCS_ADDR_W 12
`define DCS_CTRL_OFF 12'h000
`define DCS_STAT_OFF 12'h004
`define DCS_CTRL_RST 32'h0000_0000

`define DCS_CTRL_EN 0
`define DCS_CTRL_BAND_LO 1
`define DCS_CTRL_BAND_HI 2
`define DCS_CTRL_MUX 3
`define DCS_CTRL_RATE_LO 4
`define DCS_CTRL_RATE_HI 5

`define DCS_STAT_BUSY 0
`define DCS_STAT_PREV 1
`define DCS_STAT_SEL 2
`define DCS_STAT_BAD 3
`define DCS_STAT_REM_LO 8
`define DCS_STAT_REM_HI 15

`define DCS_BAND_779 2'h0
`define DCS_BAND_868 2'h1
`define DCS_BAND_915 2'h2
`define DCS_BAND_2450 2'h3

`define DCS_P4 4'ha
`define DCS_P16_0 16'h23d6
`define DCS_P16_1 16'h47ac
`define DCS_P32_0 32'hdea2_7065
`define DCS_P32_1 32'hef51_3832
`define DCS_P64 64'hb225_b1d0_d73d_f02a
`define DCS_P128 128'h988b_4e42_526d_c7a0_d465_d875_e7df_80ab
`define DCS_T84 {8'hfe, 8'h2f, 8'h97, 8'h46, 8'h1a, 8'hcb, 8'h73, \
    8'ha2, 8'h5d, 8'h8c, 8'h34, 8'he5, 8'hb9, 8'h68, 8'hd0, 8'h01}

`endif

/* core/dcs_pkg.sv */
// Types shared by the chip spreader
package dcs_pkg;

    typedef enum logic [7:0] {
        DCS_K1 = 8'h01,
        DCS_K4 = 8'h02,
        DCS_K16 = 8'h04,
        DCS_K32 = 8'h08,
        DCS_K64 = 8'h10,
        DCS_K128 = 8'h20,
        DCS_K84 = 8'h40,
        DCS_KBAD = 8'h80
    } dcs_kind_type;

    typedef enum logic [1:0] {
        DCS_IDLE = 2'h1,
        DCS_SEND = 2'h2
    } dcs_state_type;

endpackage : dcs_pkg

/* core/dcs_top.sv */
// Differential encoder and bit-to-chip spreader with APB control
`timescale 1ns/1ps
`include "dcs_defs.svh"

module dcs_top
    import dcs_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Code-bit stream from the coder
    input wire logic in_valid,
    input wire logic in_bit,
    input wire logic in_sop,
    input wire logic in_hdr,
    output logic in_ready,
    // Chip stream to the whitener
    output logic chip_valid,
    output logic chip,
    // Code-bits to the multiplexed spreader
    output logic mux_valid,
    output logic mux_bit
);

    function automatic dcs_kind_type kind_of(
        input logic [1:0] band,
        input logic [1:0] rate,
        input logic hdr
    );
        dcs_kind_type k;
        k = DCS_KBAD;
        if (hdr)
        begin
            unique case (band)
                `DCS_BAND_868: k = DCS_K16;
                `DCS_BAND_2450: k = DCS_K128;
                default: k = DCS_K64;
            endcase
        end
        else if (band == `DCS_BAND_868)
        begin
            if (rate == 2'h0)
                k = DCS_K4;
            else if (rate == 2'h1)
                k = DCS_K1;
        end
        else if (band == `DCS_BAND_2450)
        begin
            if (rate == 2'h0)
                k = DCS_K32;
            else if (rate == 2'h3)
                k = DCS_K84;
        end
        else
        begin
            unique case (rate)
                2'h0: k = DCS_K16;
                2'h2: k = DCS_K84;
                2'h3: k = DCS_K1;
                default: k = DCS_KBAD;
            endcase
        end
        return k;
    endfunction : kind_of

    function automatic logic [7:0] len_of(input dcs_kind_type k);
        logic [7:0] n;
        n = 8'h01;
        unique case (k)
            DCS_K4: n = 8'h04;
            DCS_K16: n = 8'h10;
            DCS_K32: n = 8'h20;
            DCS_K64: n = 8'h40;
            DCS_K128: n = 8'h80;
            DCS_K84: n = 8'h08;
            default: n = 8'h01;
        endcase
        return n;
    endfunction : len_of

    // Codeword left aligned, c0 in bit 127
    function automatic logic [127:0] pat_of(
        input dcs_kind_type k,
        input logic sel,
        input logic b,
        input logic [3:0] grp
    );
        logic [127:0] base;
        logic [127:0] mask;
        logic [127:0] t84;
        t84 = `DCS_T84;
        mask = ~({128{1'b1}} >> len_of(k));
        base = 128'h0;
        unique case (k)
            DCS_K4: base = {`DCS_P4, 124'h0};
            DCS_K16: base = sel ? {`DCS_P16_1, 112'h0}
                : {`DCS_P16_0, 112'h0};
            DCS_K32: base = sel ? {`DCS_P32_1, 96'h0}
                : {`DCS_P32_0, 96'h0};
            DCS_K64: base = {`DCS_P64, 64'h0};
            DCS_K128: base = `DCS_P128;
            DCS_K84: base = {t84[grp*8 +: 8], 120'h0};
            default: base = 128'h0;
        endcase
        if (k != DCS_K84 && b)
            base = base ^ mask;
        return base;
    endfunction : pat_of

    logic [31:0] ctrl_r;
    logic [127:0] sreg_r;
    logic [7:0] remain_r;
    logic [7:0] remain_nxt;
    logic [3:0] grp_r;
    logic [1:0] grp_cnt_r;
    logic prev_r;
    logic code_sel_r;
    logic bad_r;
    dcs_state_type state_r;

    logic en;
    logic [1:0] band;
    logic [1:0] rate;
    logic acc;
    dcs_kind_type kind_w;
    logic mux_w;
    logic diff_w;
    logic prev_eff;
    logic enc_w;
    logic sel_w;
    logic [1:0] grp_eff;
    logic [3:0] grp_w;
    logic load_w;
    logic alt_w;

    assign en = ctrl_r[`DCS_CTRL_EN];
    assign band = ctrl_r[`DCS_CTRL_BAND_HI:`DCS_CTRL_BAND_LO];
    assign rate = ctrl_r[`DCS_CTRL_RATE_HI:`DCS_CTRL_RATE_LO];
    assign acc = in_valid && in_ready;
    assign kind_w = kind_of(band, rate, in_hdr);
    assign mux_w = ctrl_r[`DCS_CTRL_MUX] && !in_hdr && band[1];
    assign diff_w = in_hdr || (!mux_w && rate == 2'h0);
    assign prev_eff = in_sop ? 1'b0 : prev_r;
    assign enc_w = diff_w ? (in_bit ^ prev_eff) : in_bit;
    assign alt_w = kind_w == DCS_K16 || kind_w == DCS_K32;
    assign sel_w = !in_hdr && !in_sop && code_sel_r;
    assign grp_eff = in_sop ? 2'h0 : grp_cnt_r;
    assign grp_w = {enc_w, grp_r[3:1]};
    assign load_w = acc && !mux_w
        && (kind_w != DCS_K84 || grp_eff == 2'h3);

    always_comb
    begin
        remain_nxt = (remain_r != 8'h00) ? remain_r - 8'h01 : 8'h00;
        if (load_w)
            remain_nxt = len_of(kind_w);
    end

    // APB register access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b1;
            pslverr <= paddr != `DCS_CTRL_OFF && paddr != `DCS_STAT_OFF;
            if (paddr == `DCS_CTRL_OFF)
                prdata <= ctrl_r;
            else if (paddr == `DCS_STAT_OFF)
                prdata <= {16'h0, remain_r, 4'h0, bad_r, code_sel_r,
                    prev_r, remain_r != 8'h00};
            else
                prdata <= 32'h0;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= `DCS_CTRL_RST;
        else if (psel && penable && pready && pwrite
            && paddr == `DCS_CTRL_OFF)
            ctrl_r <= {26'h0, pwdata[5:0]};
    end

    // Encoder memory, code alternation and grouping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_r <= 1'b0;
            code_sel_r <= 1'b0;
            grp_r <= 4'h0;
            grp_cnt_r <= 2'h0;
            bad_r <= 1'b0;
        end
        else if (acc)
        begin
            if (in_sop)
                prev_r <= 1'b0;
            if (diff_w)
                prev_r <= enc_w;
            if (in_sop)
                code_sel_r <= 1'b0;
            if (!in_hdr && !mux_w && alt_w)
                code_sel_r <= !sel_w;
            if (!mux_w && kind_w == DCS_K84)
            begin
                grp_r <= grp_w;
                grp_cnt_r <= grp_eff + 2'h1;
            end
            else if (in_sop)
                grp_cnt_r <= 2'h0;
            if (in_sop)
                bad_r <= 1'b0;
            if (!mux_w && kind_w == DCS_KBAD)
                bad_r <= 1'b1;
        end
    end

    // Codeword shifter, c0 first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sreg_r <= 128'h0;
            remain_r <= 8'h00;
            state_r <= DCS_IDLE;
            chip <= 1'b0;
            chip_valid <= 1'b0;
        end
        else
        begin
            chip_valid <= remain_r != 8'h00;
            chip <= (remain_r != 8'h00) ? sreg_r[127] : 1'b0;
            remain_r <= remain_nxt;
            state_r <= (remain_nxt != 8'h00) ? DCS_SEND : DCS_IDLE;
            if (load_w)
                sreg_r <= pat_of(kind_w, sel_w, enc_w, grp_w);
            else
                sreg_r <= {sreg_r[126:0], 1'b0};
        end
    end

    // Upstream stall while a codeword drains
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_ready <= 1'b0;
        else
            in_ready <= en && remain_nxt <= 8'h01;
    end

    // Hand-off to the multiplexed spreader
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mux_valid <= 1'b0;
            mux_bit <= 1'b0;
        end
        else
        begin
            mux_valid <= acc && mux_w;
            mux_bit <= (acc && mux_w) ? in_bit : 1'b0;
        end
    end

    // Checks
    property p_diff_xor;
        @(posedge pclk) disable iff (!presetn)
        acc && diff_w && !in_sop |=> prev_r == $past(in_bit ^ prev_r);
    endproperty
    a_diff_xor: assert property (p_diff_xor)
        else $error("encoder output is not raw xor previous");

    property p_sop_clear;
        @(posedge pclk) disable iff (!presetn)
        acc && in_sop && diff_w |=> prev_r == $past(in_bit);
    endproperty
    a_sop_clear: assert property (p_sop_clear)
        else $error("encoder not cleared at packet start");

    property p_n1_pass;
        @(posedge pclk) disable iff (!presetn)
        acc && !mux_w && kind_w == DCS_K1
        |=> ##1 chip_valid && chip == $past(in_bit, 2);
    endproperty
    a_n1_pass: assert property (p_n1_pass)
        else $error("unspread chip differs from input bit");

    property p_four_first;
        @(posedge pclk) disable iff (!presetn)
        acc && !mux_w && kind_w == DCS_K4
        |=> ##1 chip == !$past(enc_w, 2) ##1 chip == $past(enc_w, 3);
    endproperty
    a_four_first: assert property (p_four_first)
        else $error("four-chip codeword wrong");

    property p_stall;
        @(posedge pclk) disable iff (!presetn)
        remain_r > 8'h02 |=> !in_ready;
    endproperty
    a_stall: assert property (p_stall)
        else $error("ready raised while codeword pending");

    property p_chip_run;
        @(posedge pclk) disable iff (!presetn)
        acc && !mux_w && kind_w == DCS_K64 |=> ##1 chip_valid [*8];
    endproperty
    a_chip_run: assert property (p_chip_run)
        else $error("chip stream broke inside a codeword");

    property p_hdr_code0;
        @(posedge pclk) disable iff (!presetn)
        acc && in_sop |=> !code_sel_r;
    endproperty
    a_hdr_code0: assert property (p_hdr_code0)
        else $error("code select not zero at packet start");

    property p_alt;
        @(posedge pclk) disable iff (!presetn)
        acc && !in_hdr && !mux_w && alt_w
        |=> code_sel_r != $past(sel_w);
    endproperty
    a_alt: assert property (p_alt)
        else $error("payload code did not alternate");

    property p_mux;
        @(posedge pclk) disable iff (!presetn)
        acc && mux_w |=> mux_valid && mux_bit == $past(in_bit)
            && !(load_w);
    endproperty
    a_mux: assert property (p_mux)
        else $error("multiplexed hand-off missing");

    c_hdr: cover property (@(posedge pclk) acc && in_sop && in_hdr);
    c_group: cover property (@(posedge pclk) load_w && kind_w == DCS_K84);
    c_mux: cover property (@(posedge pclk) mux_valid);
    c_alt: cover property (@(posedge pclk) load_w && sel_w);

endmodule : dcs_top

/* testbench/dcs_peer.sv */
// Upstream bit source and downstream chip collector for the spreader
`timescale 1ns/1ps
module dcs_peer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bit stream toward the spreader
    output logic in_valid,
    output logic in_bit,
    output logic in_sop,
    output logic in_hdr,
    input wire logic in_ready,
    input wire logic slow,
    // Chip and multiplexed outputs
    input wire logic chip_valid,
    input wire logic chip,
    input wire logic mux_valid,
    input wire logic mux_bit
);
    logic [2:0] src_q [$];
    logic got_q [$];
    logic mux_q [$];
    int gap;

    // Offer bits in order, each held until taken
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_valid <= 1'b0;
            in_bit <= 1'b0;
            in_sop <= 1'b0;
            in_hdr <= 1'b0;
            gap = 0;
        end
        else
        begin
            if (chip_valid)
                got_q.push_back(chip);
            if (mux_valid)
                mux_q.push_back(mux_bit);
            if (in_valid && !in_ready)
                in_valid <= 1'b1;
            else if (gap > 0 || src_q.size() == 0)
            begin
                gap = gap > 0 ? gap - 1 : 0;
                in_valid <= 1'b0;
                in_sop <= 1'b0;
                in_bit <= ~in_bit;
            end
            else
            begin
                {in_sop, in_hdr, in_bit} <= src_q.pop_front();
                in_valid <= 1'b1;
                gap = slow ? 2 : 0;
            end
        end
    end
endmodule : dcs_peer

/* testbench/dcs_top_tb.sv */
// Self-checking bench for the chip spreader
`timescale 1ns/1ps
`include "dcs_defs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module dcs_top_tb;
    import dcs_pkg::*;
    localparam logic [127:0] P4 = 128'ha;
    localparam logic [127:0] P16_0 = 128'h23d6;
    localparam logic [127:0] P16_1 = 128'h47ac;
    localparam logic [127:0] P32_0 = 128'hdea2_7065;
    localparam logic [127:0] P32_1 = 128'hef51_3832;
    localparam logic [127:0] P64 = 128'hb225_b1d0_d73d_f02a;
    localparam logic [127:0] P128 =
        128'h988b_4e42_526d_c7a0_d465_d875_e7df_80ab;
    localparam logic [7:0] T84 [16] = '{8'h01, 8'hd0, 8'h68, 8'hb9, 8'he5,
        8'h34, 8'h8c, 8'h5d, 8'ha2, 8'h73, 8'hcb, 8'h1a, 8'h46, 8'h97,
        8'h2f, 8'hfe};
    int cf [8][3] = '{'{1, 0, 0}, '{1, 1, 0}, '{0, 0, 0}, '{2, 2, 0},
        '{0, 3, 0}, '{3, 0, 0}, '{3, 3, 0}, '{2, 0, 1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, w;
    logic in_valid, in_bit, in_sop, in_hdr, in_ready, slow;
    logic chip_valid, chip, mux_valid, mux_bit, e;
    logic eq [$];
    logic mq [$];
    int bad_count, total_checks, n;

    dcs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .in_valid, .in_bit, .in_sop, .in_hdr,
        .in_ready, .chip_valid, .chip, .mux_valid, .mux_bit);
    dcs_peer peer (.pclk, .presetn, .in_valid, .in_bit, .in_sop, .in_hdr,
        .in_ready, .slow, .chip_valid, .chip, .mux_valid, .mux_bit);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic void spr(logic [127:0] p, int m, logic b);
        for (int i = m - 1; i >= 0; i--)
            eq.push_back(p[i] ^ b);
    endfunction : spr

    // Queue one packet and build the chips it must give
    task automatic pkt(input int bd, input int rt, input int mx,
        input logic [23:0] d);
        logic x;
        logic [3:0] g;
        logic [127:0] p;
        x = 1'b0;
        g = 4'h0;
        for (int i = 0; i < 24; i++)
        begin
            peer.src_q.push_back({i == 0, i < 8, d[i]});
            p = (i % 2) ? (bd == 3 ? P32_1 : P16_1) : (bd == 3 ? P32_0 : P16_0);
            if (i < 8)
            begin
                x = x ^ d[i];
                spr(bd == 1 ? P16_0 : bd == 3 ? P128 : P64,
                    bd == 1 ? 16 : bd == 3 ? 128 : 64, x);
            end
            else if (mx && bd > 1)
                mq.push_back(d[i]);
            else if (rt == 0)
            begin
                x = x ^ d[i];
                spr(bd == 1 ? P4 : p, bd == 1 ? 4 : bd == 3 ? 32 : 16, x);
            end
            else if ((rt == 2 && bd != 3) || (rt == 3 && bd == 3))
            begin
                g[i % 4] = d[i];
                if (i % 4 == 3)
                    spr({120'h0, T84[g]}, 8, 1'b0);
            end
            else
                spr(128'h0, 1, d[i]);
        end
    endtask : pkt

    initial
    begin
        {presetn, psel, penable, pwrite, slow} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        bad_count = 0;
        total_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DCS_CTRL_OFF, 32'h0);
        `CHK(r, `DCS_CTRL_RST)
        apb(1'b0, 12'h008, 32'h0);
        `CHK({e, r}, 33'h1_0000_0000)
        for (int s = 0; s < 8; s++)
        begin
            w = {26'h0, cf[s][1][1:0], cf[s][2][0], cf[s][0][1:0], 1'b1};
            apb(1'b1, `DCS_CTRL_OFF, w);
            apb(1'b0, `DCS_CTRL_OFF, 32'h0);
            `CHK(r, w)
            slow <= s[0];
            pkt(cf[s][0], cf[s][1], cf[s][2], 24'h3c96a5);
            pkt(cf[s][0], cf[s][1], cf[s][2], 24'hc3695b);
            n = 0;
            while ((peer.got_q.size() < eq.size() ||
                peer.mux_q.size() < mq.size()) && n < 20000)
            begin
                @(posedge pclk);
                n++;
            end
            repeat (20) @(posedge pclk);
            `CHK(peer.got_q.size(), eq.size())
            `CHK(peer.mux_q.size(), mq.size())
            foreach (eq[i])
                `CHK(peer.got_q[i], eq[i])
            foreach (mq[i])
                `CHK(peer.mux_q[i], mq[i])
            eq.delete();
            mq.delete();
            peer.got_q.delete();
            peer.mux_q.delete();
        end
        apb(1'b0, `DCS_STAT_OFF, 32'h0);
        `CHK(r, 32'h0000_0002)
        apb(1'b1, 12'h008, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b0, `DCS_CTRL_OFF, 32'h0);
        `CHK(r, w)
        final_report();
    end

    initial
    begin
        #480000;
        bad_count++;
        final_report();
    end
endmodule : dcs_top_tb
